// File: verilog/ddc_defines.vh
// shared constants for the dual converter serial command decoder
`ifndef DDC_DEFINES_VH
`define DDC_DEFINES_VH

// serial word layout
`define DDC_WORD_BITS 16
`define DDC_CNT_BITS 5
`define DDC_CMD_MSB 15
`define DDC_CMD_LSB 13
`define DDC_SEL_MSB 15
`define DDC_SEL_LSB 14
`define DDC_PWD_BIT 12
`define DDC_DATA_MSB 11
`define DDC_DATA_BITS 12
`define DDC_IMP_MSB 11
`define DDC_IMP_LSB 10

// command codes in bits 15..13 when bit 12 is zero
`define DDC_CMD_STORE_A 3'h0
`define DDC_CMD_STORE_B 3'h1
`define DDC_CMD_UPD_A 3'h2
`define DDC_CMD_UPD_A_XFER_B 3'h3
`define DDC_CMD_UPD_B 3'h4
`define DDC_CMD_UPD_B_XFER_A 3'h5
`define DDC_CMD_UPD_AB 3'h6
`define DDC_CMD_XFER_AB 3'h7

// channel select in bits 15..14 of a power-down word
`define DDC_SEL_A 2'h1
`define DDC_SEL_B 2'h2

// impedance field of a power-down word
`define DDC_IMP_1K 2'h1
`define DDC_IMP_100K 2'h2

// channel output state
`define DDC_PD_ACTIVE 2'h0
`define DDC_PD_1K 2'h1
`define DDC_PD_100K 2'h2
`define DDC_PD_HIZ 2'h3

// reset values
`define DDC_CODE_RST 12'h000
`define DDC_WORD_RST 16'h0000

// data buffer
`define DDC_FIFO_DEPTH 32
`define DDC_FIFO_AW 5

`endif

// File: verilog/ddc_fifo.v
// word buffer between the serial front end and the command decoder
`timescale 1ns/1ps
module ddc_fifo
#(
    parameter WIDTH = 16,
    parameter DEPTH = 32,
    parameter AW = 5
)
(
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    // fill side
    input wire in_valid,
    input wire [WIDTH-1:0] in_data,
    output wire in_ready,
    // drain side
    output wire out_valid,
    output wire [WIDTH-1:0] out_data,
    input wire out_ready
);

    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_ff;
    reg [AW-1:0] rd_ptr_ff;
    reg [AW:0] count_ff;
    wire do_push;
    wire do_pop;

    assign in_ready = (count_ff != DEPTH[AW:0]);
    assign out_valid = (count_ff != {(AW+1){1'b0}});
    assign out_data = mem_ff[rd_ptr_ff];
    assign do_push = in_valid & in_ready;
    assign do_pop = out_valid & out_ready;

    // storage is not reset; count guards reads
    always @(posedge clk_sys)
    begin
        if (do_push)
        begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
            end
            if (do_pop)
            begin
                rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
            end
            if (do_push && !do_pop)
            begin
                count_ff <= count_ff + 1'b1;
            end
            else if (do_pop && !do_push)
            begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

endmodule // ddc_fifo

// File: verilog/ddc_decoder.v
// serial front end and command decoder for a dual 12-bit converter
`timescale 1ns/1ps
`include "ddc_defines.vh"
module ddc_decoder
#(
    parameter DATA_BITS = `DDC_DATA_BITS,
    parameter FIFO_DEPTH = `DDC_FIFO_DEPTH,
    parameter FIFO_AW = `DDC_FIFO_AW
)
(
    // system clock and reset
    input wire clk_sys,
    input wire nrst,
    // serial link from the host
    input wire sync_n,
    input wire sclk,
    input wire serial_data_in,
    output reg serial_data_out_ff,
    // control pins
    input wire async_clear_n,
    input wire chain_mode_enable,
    input wire power_down_pin,
    // converter codes
    output reg [DATA_BITS-1:0] dac_a_ff,
    output reg [DATA_BITS-1:0] dac_b_ff,
    // channel output state
    output reg [1:0] pd_a_ff,
    output reg [1:0] pd_b_ff,
    // status
    output reg frame_lost_ff
);

    localparam ST_IDLE = 2'b01;
    localparam ST_APPLY = 2'b10;

    // synchronisers; bit order sclk, sync_n, data, clear, pin, chain
    localparam [5:0] PIN_IDLE = 6'h10;
    wire [5:0] pin_raw;
    reg [5:0] pin_s1_ff;
    reg [5:0] pin_s2_ff;
    reg sclk_s3_ff;
    reg sync_s3_ff;
    wire sclk_s2_ff = pin_s2_ff[5];
    wire sync_s2_ff = pin_s2_ff[4];
    wire sdi_s2_ff = pin_s2_ff[3];
    wire clr_s2_ff = pin_s2_ff[2];
    wire pdp_s2_ff = pin_s2_ff[1];
    wire chain_s2_ff = pin_s2_ff[0];

    // front end
    reg [`DDC_WORD_BITS-1:0] shift_ff;
    reg [`DDC_CNT_BITS-1:0] bitcnt_ff;
    reg armed_ff;
    reg frame_ok_ff;
    reg push_valid_ff;
    reg [`DDC_WORD_BITS-1:0] push_word_ff;
    reg [`DDC_WORD_BITS-1:0] nxt_shift;
    reg [`DDC_CNT_BITS-1:0] nxt_bitcnt;

    // decoder
    reg [1:0] state_ff;
    reg [`DDC_WORD_BITS-1:0] word_ff;
    reg [DATA_BITS-1:0] hold_a_ff;
    reg [DATA_BITS-1:0] hold_b_ff;
    reg [1:0] mode_a_ff;
    reg [1:0] mode_b_ff;
    reg [1:0] imp_mode;

    wire sclk_fall;
    wire sync_fall;
    wire sync_rise;
    wire frame_done;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [`DDC_WORD_BITS-1:0] fifo_out_data;
    wire fifo_out_ready;
    wire clr_all_n;
    wire [2:0] cmd;
    wire [DATA_BITS-1:0] code;
    wire [1:0] sel;

    assign sclk_fall = sclk_s3_ff & ~sclk_s2_ff;
    assign sync_fall = sync_s3_ff & ~sync_s2_ff;
    assign sync_rise = ~sync_s3_ff & sync_s2_ff;
    assign frame_done = sync_rise & frame_ok_ff & (bitcnt_ff == `DDC_WORD_BITS);
    assign clr_all_n = nrst & async_clear_n;
    assign cmd = word_ff[`DDC_CMD_MSB:`DDC_CMD_LSB];
    assign code = word_ff[`DDC_DATA_MSB:0];
    assign sel = word_ff[`DDC_SEL_MSB:`DDC_SEL_LSB];
    // words finished while clear is held are drained and dropped
    assign fifo_out_ready = (state_ff == ST_IDLE) | ~clr_s2_ff;

    assign pin_raw = {sclk, sync_n, serial_data_in, async_clear_n, power_down_pin,
        chain_mode_enable};

    // two-flop synchronisers; third stage only feeds the edge detectors
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_s1_ff <= PIN_IDLE;
            pin_s2_ff <= PIN_IDLE;
            sclk_s3_ff <= 1'b0;
            sync_s3_ff <= 1'b1;
        end
        else
        begin
            pin_s1_ff <= pin_raw;
            pin_s2_ff <= pin_s1_ff;
            sclk_s3_ff <= sclk_s2_ff;
            sync_s3_ff <= sync_s2_ff;
        end
    end

    // shift register and bit count
    always @*
    begin
        nxt_shift = shift_ff;
        nxt_bitcnt = bitcnt_ff;
        if (sync_fall)
            nxt_bitcnt = {`DDC_CNT_BITS{1'b0}};
        if (sclk_fall && !sync_s2_ff)
        begin
            nxt_shift = {shift_ff[`DDC_WORD_BITS-2:0], sdi_s2_ff};
            if (nxt_bitcnt != `DDC_WORD_BITS)
                nxt_bitcnt = nxt_bitcnt + 1'b1;
        end
    end

    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            shift_ff <= `DDC_WORD_RST;
            bitcnt_ff <= {`DDC_CNT_BITS{1'b0}};
            armed_ff <= 1'b1;
            frame_ok_ff <= 1'b0;
            push_valid_ff <= 1'b0;
            push_word_ff <= `DDC_WORD_RST;
            serial_data_out_ff <= 1'b0;
            frame_lost_ff <= 1'b0;
        end
        else
        begin
            shift_ff <= nxt_shift;
            bitcnt_ff <= nxt_bitcnt;
            // chain mode needs one sclk fall with sync high before a new word
            if (!chain_s2_ff)
                armed_ff <= 1'b1;
            else if (sync_rise)
                armed_ff <= 1'b0;
            else if (sclk_fall && sync_s2_ff)
                armed_ff <= 1'b1;
            if (sync_fall)
                frame_ok_ff <= armed_ff;
            // daisy-chain output: bit leaving the shift register
            if (!chain_s2_ff)
            begin
                serial_data_out_ff <= 1'b0;
            end
            else if (sclk_fall && !sync_s2_ff)
            begin
                serial_data_out_ff <= shift_ff[`DDC_WORD_BITS-1];
            end
            push_valid_ff <= frame_done;
            if (frame_done)
                push_word_ff <= shift_ff;
            frame_lost_ff <= push_valid_ff & ~fifo_in_ready;
        end
    end

    ddc_fifo
    #(
        .WIDTH(`DDC_WORD_BITS),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    )
    u_fifo
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .in_valid(push_valid_ff),
        .in_data(push_word_ff),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(fifo_out_ready)
    );

    // fetch/apply sequencer
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= ST_IDLE;
            word_ff <= `DDC_WORD_RST;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    if (fifo_out_valid && clr_s2_ff)
                    begin
                        word_ff <= fifo_out_data;
                        state_ff <= ST_APPLY;
                    end
                end
                ST_APPLY: state_ff <= ST_IDLE;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // impedance field to channel state
    always @*
    begin
        case (word_ff[`DDC_IMP_MSB:`DDC_IMP_LSB])
            `DDC_IMP_1K: imp_mode = `DDC_PD_1K;
            `DDC_IMP_100K: imp_mode = `DDC_PD_100K;
            default: imp_mode = `DDC_PD_HIZ;
        endcase
    end

    // input, output and mode registers; clear pin acts without the clock
    always @(posedge clk_sys or negedge clr_all_n)
    begin
        if (!clr_all_n)
        begin
            hold_a_ff <= `DDC_CODE_RST;
            hold_b_ff <= `DDC_CODE_RST;
            dac_a_ff <= `DDC_CODE_RST;
            dac_b_ff <= `DDC_CODE_RST;
            mode_a_ff <= `DDC_PD_ACTIVE;
            mode_b_ff <= `DDC_PD_ACTIVE;
        end
        else if (state_ff == ST_APPLY)
        begin
            if (word_ff[`DDC_PWD_BIT])
            begin
                if (sel != `DDC_SEL_B)
                begin
                    mode_a_ff <= imp_mode;
                end
                if (sel != `DDC_SEL_A)
                begin
                    mode_b_ff <= imp_mode;
                end
            end
            else
            begin
                case (cmd)
                    `DDC_CMD_STORE_A: hold_a_ff <= code;
                    `DDC_CMD_STORE_B: hold_b_ff <= code;
                    `DDC_CMD_UPD_A:
                    begin
                        hold_a_ff <= code;
                        dac_a_ff <= code;
                        mode_a_ff <= `DDC_PD_ACTIVE;
                    end
                    `DDC_CMD_UPD_A_XFER_B:
                    begin
                        hold_a_ff <= code;
                        dac_a_ff <= code;
                        dac_b_ff <= hold_b_ff;
                        mode_a_ff <= `DDC_PD_ACTIVE;
                        mode_b_ff <= `DDC_PD_ACTIVE;
                    end
                    `DDC_CMD_UPD_B:
                    begin
                        hold_b_ff <= code;
                        dac_b_ff <= code;
                        mode_b_ff <= `DDC_PD_ACTIVE;
                    end
                    `DDC_CMD_UPD_B_XFER_A:
                    begin
                        hold_b_ff <= code;
                        dac_b_ff <= code;
                        dac_a_ff <= hold_a_ff;
                        mode_a_ff <= `DDC_PD_ACTIVE;
                        mode_b_ff <= `DDC_PD_ACTIVE;
                    end
                    `DDC_CMD_UPD_AB:
                    begin
                        hold_a_ff <= code;
                        hold_b_ff <= code;
                        dac_a_ff <= code;
                        dac_b_ff <= code;
                        mode_a_ff <= `DDC_PD_ACTIVE;
                        mode_b_ff <= `DDC_PD_ACTIVE;
                    end
                    default:
                    begin
                        dac_a_ff <= hold_a_ff;
                        dac_b_ff <= hold_b_ff;
                        mode_a_ff <= `DDC_PD_ACTIVE;
                        mode_b_ff <= `DDC_PD_ACTIVE;
                    end
                endcase
            end
        end
    end

    // power-down pin overrides both channels to floating
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pd_a_ff <= `DDC_PD_ACTIVE;
            pd_b_ff <= `DDC_PD_ACTIVE;
        end
        else
        begin
            pd_a_ff <= pdp_s2_ff ? `DDC_PD_HIZ : mode_a_ff;
            pd_b_ff <= pdp_s2_ff ? `DDC_PD_HIZ : mode_b_ff;
        end
    end

endmodule // ddc_decoder

// File: tb/ddc_checker.sv
// concurrent checks on the decoder's ports
`timescale 1ns/1ps
module ddc_checker
#(
    parameter DATA_BITS = 12
)
(
    // clock, reset and pins
    input wire clk_sys,
    input wire nrst,
    input wire sync_n,
    input wire async_clear_n,
    input wire chain_mode_enable,
    input wire power_down_pin,
    // outputs
    input wire serial_data_out_ff,
    input wire [DATA_BITS-1:0] dac_a_ff,
    input wire [DATA_BITS-1:0] dac_b_ff,
    input wire [1:0] pd_a_ff,
    input wire [1:0] pd_b_ff
);
    reg [5:0] since_ff;
    reg sync_q_ff;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    // cycles since frame sync last rose, saturating
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            since_ff <= 6'h3F;
            sync_q_ff <= 1'b1;
        end
        else
        begin
            sync_q_ff <= sync_n;
            if (sync_n && !sync_q_ff)
                since_ff <= 6'h00;
            else if (since_ff != 6'h3F)
                since_ff <= since_ff + 6'h01;
        end
    end

    property p_clr_a;
        !async_clear_n |-> dac_a_ff == {DATA_BITS{1'b0}};
    endproperty
    a_clr_a: assert property (p_clr_a) else $error("dac a not zero in clear");
    property p_clr_b;
        !async_clear_n |-> dac_b_ff == {DATA_BITS{1'b0}};
    endproperty
    a_clr_b: assert property (p_clr_b) else $error("dac b not zero in clear");
    property p_clr_pd;
        !async_clear_n [*2] ##0 !power_down_pin |-> pd_a_ff == 2'h0 && pd_b_ff == 2'h0;
    endproperty
    a_clr_pd: assert property (p_clr_pd) else $error("mode kept in clear");
    property p_upd;
        async_clear_n && ($changed(dac_a_ff) || $changed(dac_b_ff)) |-> since_ff <= 6'h0E;
    endproperty
    a_upd: assert property (p_upd) else $error("code changed without frame end");
    property p_pd_src;
        async_clear_n && $changed(pd_a_ff) && !power_down_pin && !$past(power_down_pin, 5)
            |-> since_ff <= 6'h0F;
    endproperty
    a_pd_src: assert property (p_pd_src) else $error("mode changed without frame");
    property p_pd_force;
        power_down_pin [*6] |-> pd_a_ff == 2'h3 && pd_b_ff == 2'h3;
    endproperty
    a_pd_force: assert property (p_pd_force) else $error("pin did not float outputs");
    property p_sdo_off;
        !chain_mode_enable [*4] |-> !serial_data_out_ff;
    endproperty
    a_sdo_off: assert property (p_sdo_off) else $error("chain out active");
    property p_rst;
        $rose(nrst) |-> dac_a_ff == 0 && dac_b_ff == 0 && pd_a_ff == 0 && pd_b_ff == 0;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    c_upd: cover property ($changed(dac_a_ff));
    c_pd: cover property (pd_a_ff == 2'h1);
    c_clr: cover property ($fell(async_clear_n));
endmodule // ddc_checker

bind ddc_decoder ddc_checker #(.DATA_BITS(DATA_BITS)) u_chk (.clk_sys, .nrst, .sync_n,
    .async_clear_n, .chain_mode_enable, .power_down_pin, .serial_data_out_ff, .dac_a_ff,
    .dac_b_ff, .pd_a_ff, .pd_b_ff);

// File: tb/ddc_host_model.sv
// host serial port model sending frames
`timescale 1ns/1ps
module ddc_host_model
(
    // pacing clock
    input wire clk_sys,
    // serial link
    output logic sync_n,
    output logic sclk,
    output logic serial_data_in,
    input wire serial_data_out
);
    logic [15:0] echo;
    logic skip_tail;
    initial
    begin
        sync_n = 1'b1;
        sclk = 1'b0;
        serial_data_in = 1'b0;
        echo = 16'h0000;
        skip_tail = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // sclk idles low, 800 ns period
    task automatic send(input logic [15:0] w, input int nbits);
        int i;
        wait_n(1);
        sync_n = 1'b0;
        wait_n(4);
        for (i = 0; i < nbits; i++)
        begin
            // chained bit left by the previous fall
            if (i > 0)
                echo = {echo[14:0], serial_data_out};
            sclk = 1'b1;
            serial_data_in = w[15-i];
            wait_n(4);
            sclk = 1'b0;
            wait_n(4);
        end
        echo = {echo[14:0], serial_data_out};
        sync_n = 1'b1;
        serial_data_in = ~serial_data_in;
        wait_n(4);
        // a skipped tail leaves a chained device unarmed
        if (!skip_tail)
        begin
            sclk = 1'b1;
            wait_n(4);
            sclk = 1'b0;
        end
        wait_n(4);
    endtask
endmodule // ddc_host_model

// File: tb/tb_top.sv
// self-checking testbench for the serial command decoder
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic async_clear_n = 1'b1;
    logic chain_mode_enable = 1'b0;
    logic power_down_pin = 1'b0;
    logic [31:0] rng = 32'h744CB692;
    wire sync_n, sclk, serial_data_in, serial_data_out_ff, frame_lost_ff;
    wire [11:0] dac_a_ff, dac_b_ff;
    wire [1:0] pd_a_ff, pd_b_ff;
    int n_mismatch = 0, checks = 0, cyc = 0;
    int ha = 0, hb = 0, da = 0, db = 0, pa = 0, pb = 0;
    int n_lost = 0;
    logic [15:0] pend[$];

    always #50 clk_sys = ~clk_sys;

    ddc_decoder DUT (.clk_sys, .nrst, .sync_n, .sclk, .serial_data_in, .serial_data_out_ff,
        .async_clear_n, .chain_mode_enable, .power_down_pin, .dac_a_ff, .dac_b_ff, .pd_a_ff,
        .pd_b_ff, .frame_lost_ff);
    ddc_host_model host (.clk_sys, .sync_n, .sclk, .serial_data_in,
        .serial_data_out(serial_data_out_ff));

    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic check_all();
        chk("dac_a", dac_a_ff, da);
        chk("dac_b", dac_b_ff, db);
        chk("pd_a", pd_a_ff, pa);
        chk("pd_b", pd_b_ff, pb);
    endtask

    // reference model of one complete word
    task automatic apply(input logic [15:0] w);
        int d, m, c;
        d = w[11:0];
        c = w[15:13];
        m = (w[11:10] == 2'h1) ? 1 : ((w[11:10] == 2'h2) ? 2 : 3);
        if (w[12])
        begin
            if (w[15:14] != 2'h2)
                pa = m;
            if (w[15:14] != 2'h1)
                pb = m;
        end
        else
        begin
            if (c == 0 || c == 2 || c == 3 || c == 6)
                ha = d;
            if (c == 1 || c == 4 || c == 5 || c == 6)
                hb = d;
            if (c == 2 || c == 3 || c >= 5)
            begin
                da = ha;
                pa = 0;
            end
            if (c >= 3)
            begin
                db = hb;
                pb = 0;
            end
        end
    endtask

    task automatic xfer(input logic [15:0] w, input int n);
        host.send(w, n);
        if (n == 16)
            pend.push_back(w);
        repeat (4) @(negedge clk_sys);
        while (pend.size() > 0)
            apply(pend.pop_front());
        check_all();
    endtask

    always @(posedge clk_sys)
    begin
        cyc++;
        if (nrst && frame_lost_ff !== 1'b0)
            n_lost++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    initial
    begin
        int i;
        logic [31:0] r;
        repeat (16) @(negedge clk_sys);
        nrst = 1'b1;
        @(negedge clk_sys);
        check_all();
        $display("test reset done");
        for (i = 0; i < 16; i++)
        begin
            r = rnd();
            xfer({i[2:0], 1'b0, r[11:0]}, 16);
        end
        $display("test commands done");
        xfer(16'h4ABC, 10);
        $display("test short frame done");
        for (i = 0; i < 16; i++)
        begin
            r = rnd();
            xfer({i[3:2], r[10], 1'b1, i[1:0], r[9:0]}, 16);
        end
        xfer(16'hC5A5, 16);
        power_down_pin = 1'b1;
        repeat (8) @(negedge clk_sys);
        chk("pd_a_pin", pd_a_ff, 2'h3);
        chk("pd_b_pin", pd_b_ff, 2'h3);
        power_down_pin = 1'b0;
        repeat (8) @(negedge clk_sys);
        check_all();
        $display("test power down done");
        chain_mode_enable = 1'b1;
        repeat (4) @(negedge clk_sys);
        host.skip_tail = 1'b1;
        xfer(16'h2055, 16);
        chk("sdo_echo", host.echo, 16'hC5A5);
        host.skip_tail = 1'b0;
        host.send(16'h8AAA, 16);
        repeat (4) @(negedge clk_sys);
        check_all();
        chk("sdo_echo", host.echo, 16'h2055);
        xfer(16'h8AAA, 16);
        chk("sdo_echo", host.echo, 16'h8AAA);
        chain_mode_enable = 1'b0;
        $display("test chain mode done");
        xfer(16'hC123, 16);
        chk("sdo_echo", host.echo, 16'h0000);
        xfer(16'hD400, 16);
        async_clear_n = 1'b0;
        {ha, hb, da, db, pa, pb} = '0;
        @(negedge clk_sys);
        chk("dac_a_clr", dac_a_ff, 12'h000);
        chk("dac_b_clr", dac_b_ff, 12'h000);
        host.send(16'h4321, 16);
        repeat (4) @(negedge clk_sys);
        async_clear_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        check_all();
        xfer(16'h2123, 16);
        xfer(16'hE000, 16);
        xfer(16'h4FFF, 16);
        $display("test clear done");
        chk("frame_lost", n_lost, 0);
        stop_test();
    end
endmodule // tb_top
